// ### verilog/cpc_pkg.sv
// constants, field layout and lookup tables of the codec path control bank
package cpc_pkg;
	// register indices; byte address is four times the index
	localparam int CPC_ADDR_W = 8;
	localparam logic [5:0] CPC_IDX_TRACK = 6'h0E;
	localparam logic [5:0] CPC_IDX_ADC_ONE = 6'h0F;
	localparam logic [5:0] CPC_IDX_ADC_TWO = 6'h10;
	localparam logic [5:0] CPC_IDX_FAST = 6'h11;
	localparam logic [5:0] CPC_IDX_PATH_CFG = 6'h12;
	localparam logic [5:0] CPC_IDX_STATUS = 6'h13;
	// reset values
	localparam logic [7:0] CPC_RST_TRACK = 8'h00;
	localparam logic [7:0] CPC_RST_ADC_ONE = 8'h00;
	localparam logic [7:0] CPC_RST_ADC_TWO = 8'h00;
	localparam logic [7:0] CPC_RST_FAST = 8'h00;
	localparam logic [1:0] CPC_RST_FILT = 2'h0;
	localparam logic [2:0] CPC_RST_RATE = 3'h2;
	// tracking_supply_control fields
	localparam int CPC_TRK_FLIP = 7;
	localparam int CPC_TRK_OFS_LO = 4;
	localparam int CPC_TRK_LEAD_LO = 0;
	// adc_control_one fields; bits 7:6 reserved
	localparam int CPC_ADC1_LEVEL = 5;
	localparam int CPC_ADC1_HPF = 4;
	localparam logic [7:0] CPC_ADC1_MASK = 8'h3F;
	// adc_control_two fields
	localparam int CPC_ADC2_SILENCE_LO = 4;
	localparam int CPC_ADC2_POWER_LO = 0;
	// fast_path_control fields; bit 4 reserved
	localparam int CPC_FAST_GATE_LO = 5;
	localparam logic [7:0] CPC_FAST_MASK = 8'hEF;
	// path_config fields
	localparam int CPC_CFG_FILT_LO = 0;
	localparam int CPC_CFG_GAIN = 2;
	localparam int CPC_CFG_RATE_LO = 4;
	// fifth dac filter select codes
	localparam logic [1:0] CPC_FILT_TRACKING = 2'h2;
	localparam logic [1:0] CPC_FILT_RESERVED = 2'h3;
	// sample rates 0..5: 32, 44.1, 48, 64, 88.2, 96 kHz
	localparam logic [2:0] CPC_RATE_LAST = 3'h5;
	localparam logic [5:0] CPC_OFFSET_STEP = 6'h03;
	// noise gate codes
	localparam logic [2:0] CPC_GATE_WIDE = 3'h6;
	localparam logic [2:0] CPC_GATE_OFF = 3'h7;
	localparam logic [4:0] CPC_GATE_BASE = 5'h0D;
	localparam logic [4:0] CPC_GATE_WIDE_BITS = 5'h18;
	// bus responses
	localparam logic [1:0] CPC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CPC_RESP_SLVERR = 2'h2;
	// lead delay in samples, per rate and code
	localparam logic [5:0] CPC_LEAD_TBL [0:5][0:15] = '{
		'{6'h00, 6'h03, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A,
		  6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h0F, 6'h10},
		'{6'h00, 6'h04, 6'h07, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
		  6'h0E, 6'h0F, 6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h16},
		'{6'h00, 6'h05, 6'h07, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E,
		  6'h0F, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h17, 6'h18},
		'{6'h00, 6'h06, 6'h0A, 6'h0D, 6'h0E, 6'h10, 6'h12, 6'h13,
		  6'h15, 6'h16, 6'h18, 6'h1A, 6'h1B, 6'h1D, 6'h1E, 6'h20},
		'{6'h00, 6'h09, 6'h0D, 6'h12, 6'h14, 6'h16, 6'h18, 6'h1B,
		  6'h1D, 6'h1F, 6'h21, 6'h24, 6'h26, 6'h28, 6'h2A, 6'h2C},
		'{6'h00, 6'h0A, 6'h0E, 6'h13, 6'h16, 6'h18, 6'h1A, 6'h1D,
		  6'h1F, 6'h22, 6'h24, 6'h26, 6'h29, 6'h2B, 6'h2E, 6'h30}
	};
endpackage

// ### verilog/cpc_decode_if.sv
// settings passed to the path decoder and the values it derives
`timescale 1ns/1ps
`default_nettype none
interface cpc_decode_if;
	logic [3:0] lead_code;
	logic [2:0] rate;
	logic [2:0] offset_code;
	logic ref_flip;
	logic ref_gain;
	logic [1:0] filt;
	logic [2:0] gate_code;
	logic [5:0] lead_samples;
	logic [5:0] offset_pct;
	logic tracking;
	logic [4:0] gate_bits;
	modport bank (output lead_code, rate, offset_code, ref_flip, ref_gain,
		filt, gate_code, input lead_samples, offset_pct, tracking, gate_bits);
	modport decoder (input lead_code, rate, offset_code, ref_flip, ref_gain,
		filt, gate_code, output lead_samples, offset_pct, tracking, gate_bits);
endinterface
`default_nettype wire

// ### verilog/cpc_path_decode.sv
// combinational decode of lead delay, supply offset and noise gate depth
`timescale 1ns/1ps
`default_nettype none
module cpc_path_decode
	import cpc_pkg::*;
(
	cpc_decode_if.decoder dec
);
	logic [5:0] base_pct;

	// tracking mode only for the one filter code
	assign dec.tracking = (dec.filt == CPC_FILT_TRACKING); // see R15
	// lead delay as whole samples of the selected rate
	assign dec.lead_samples = CPC_LEAD_TBL[dec.rate][dec.lead_code]; // see R5 R6
	// three percent per code step, doubled at gain two in flipped mode
	assign base_pct = 6'(dec.offset_code * CPC_OFFSET_STEP); // see R3
	assign dec.offset_pct = (dec.ref_flip && dec.ref_gain) ?
		6'(base_pct << 1) : base_pct; // see R4

	// gate depth in upper bits, zero when the gate is off
	always_comb begin
		unique case (dec.gate_code)
			CPC_GATE_OFF: dec.gate_bits = 5'h00; // see R13
			CPC_GATE_WIDE: dec.gate_bits = CPC_GATE_WIDE_BITS; // see R13
			default: dec.gate_bits = 5'(CPC_GATE_BASE + dec.gate_code); // see R13
		endcase
	end
endmodule // cpc_path_decode
`default_nettype wire

// ### verilog/cpc_path_regs.sv
// AXI4-Lite control register bank for the codec supply, adc and fast paths
// Operation
// R1 - tracking mode: flip bit moves fifth dac reference from zero to full scale
// R2 - outside tracking mode: flip bit inverts fifth dac output data
// R3 - offset code adds code times three percent of full scale
// R4 - flip and gain both set: offset is doubled
// R5 - lead code adds group delay to main dacs; zero adds none
// R6 - lead codes map to whole sample counts per sample rate
// R7 - software changes lead delay only with paths down and dacs muted
// R8 - software sets supply level bit to match the analog supply
// R9 - highpass enable bit filters adc data, else bypass
// R10 - per adc invert bit negates that channel
// R11 - per adc silence bits 7..4 mute that channel
// R12 - per adc power off bits 3..0 power down that channel
// R13 - fast path gate code picks threshold depth or disables gate
// R14 - per fast path invert bit negates that channel input
// R15 - filter code 10 selects tracking mode; code 11 reserved
// R16 - in flipped mode gain bit sets tracking gain one or two
// R17 - software writes zero to reserved bits, ignores their read value
`timescale 1ns/1ps
`default_nettype none
module cpc_path_regs
	import cpc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic [CPC_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic [2:0] S_AXI_AWPROT,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [CPC_ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic [2:0] S_AXI_ARPROT,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic FIFTH_DAC_TRACKING,
	output logic SUPPLY_REF_FULL_SCALE,
	output logic FIFTH_DAC_DATA_INVERT,
	output logic SUPPLY_TRACK_GAIN_TWO,
	output logic [5:0] SUPPLY_DC_OFFSET_PCT,
	output logic [5:0] LEAD_DELAY_SAMPLES,
	output logic SUPPLY_LEVEL_SEL,
	output logic HIGHPASS_EN,
	output logic [3:0] ADC_POLARITY_FLIP,
	output logic [3:0] ADC_SILENCE,
	output logic [3:0] ADC_POWER_OFF,
	output logic [4:0] FAST_PATH_GATE_BITS,
	output logic [3:0] FAST_PATH_POLARITY_FLIP
);
	typedef enum logic [1:0] {
		CPC_WR_COLLECT = 2'b01,
		CPC_WR_RESP = 2'b10
	} cpc_wr_type;

	typedef enum logic [1:0] {
		CPC_RD_IDLE = 2'b01,
		CPC_RD_DATA = 2'b10
	} cpc_rd_type;

	typedef struct packed {
		logic [7:0] track;
		logic [7:0] adc_one;
		logic [7:0] adc_two;
		logic [7:0] fast;
		logic [1:0] filt;
		logic gain;
		logic [2:0] rate;
		logic tracking;
		logic ref_full;
		logic data_inv;
		logic gain_two;
		logic [5:0] offset_pct;
		logic [5:0] lead_samples;
		logic [4:0] gate_bits;
		cpc_wr_type wr;
		cpc_rd_type rd;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [5:0] waddr;
		logic [7:0] wdata;
		logic wlane;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} cpc_state_type;

	cpc_state_type s_q;
	cpc_state_type s_d;
	cpc_decode_if dec ();

	// word index of a byte address; shared by both channels
	function automatic logic [5:0] word_index(
		input logic [CPC_ADDR_W-1:0] addr
	);
		word_index = addr[CPC_ADDR_W-1:2];
	endfunction

	function automatic logic is_mapped(input logic [5:0] idx);
		is_mapped = (idx >= CPC_IDX_TRACK) && (idx <= CPC_IDX_STATUS);
	endfunction

	// stored settings feed the decoder
	assign dec.lead_code = s_q.track[CPC_TRK_LEAD_LO +: 4];
	assign dec.offset_code = s_q.track[CPC_TRK_OFS_LO +: 3];
	assign dec.ref_flip = s_q.track[CPC_TRK_FLIP];
	assign dec.ref_gain = s_q.gain;
	assign dec.filt = s_q.filt;
	assign dec.rate = s_q.rate;
	assign dec.gate_code = s_q.fast[CPC_FAST_GATE_LO +: 3];

	cpc_path_decode u_decode (
		.dec(dec)
	);

	// next state: bus handshakes, register writes, derived path controls
	always_comb begin
		logic flip;
		logic [5:0] idx;
		logic [7:0] wd;
		flip = 1'b0;
		idx = 6'h00;
		wd = 8'h00;
		s_d = s_q;
		flip = s_q.track[CPC_TRK_FLIP];

		// derived controls registered so every output leaves a flop
		s_d.tracking = dec.tracking;
		s_d.ref_full = dec.tracking && flip; // see R1
		s_d.data_inv = !dec.tracking && flip; // see R2
		s_d.gain_two = flip && s_q.gain; // see R16
		s_d.offset_pct = dec.offset_pct; // see R3 R4
		s_d.lead_samples = dec.lead_samples; // see R5 R6
		s_d.gate_bits = dec.gate_bits; // see R13

		// write channel: address and data taken in either order
		unique case (s_q.wr)
			CPC_WR_COLLECT: begin
				if (S_AXI_AWVALID && s_q.awready) begin
					s_d.awready = 1'b0;
					s_d.waddr = word_index(S_AXI_AWADDR);
				end
				if (S_AXI_WVALID && s_q.wready) begin
					s_d.wready = 1'b0;
					s_d.wdata = S_AXI_WDATA[7:0];
					s_d.wlane = S_AXI_WSTRB[0];
				end
				// both held: commit, one cycle after the later one
				if (!s_q.awready && !s_q.wready) begin
					idx = s_q.waddr;
					wd = s_q.wdata;
					s_d.wr = CPC_WR_RESP;
					s_d.bvalid = 1'b1;
					s_d.bresp = is_mapped(idx) ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
					// only byte lane 0 carries register data
					if (s_q.wlane) begin
						unique case (idx)
							CPC_IDX_TRACK: s_d.track = wd;
							// reserved bits forced to zero
							CPC_IDX_ADC_ONE: s_d.adc_one = wd & CPC_ADC1_MASK;
							CPC_IDX_ADC_TWO: s_d.adc_two = wd;
							CPC_IDX_FAST: s_d.fast = wd & CPC_FAST_MASK;
							CPC_IDX_PATH_CFG: begin
								// reserved filter code keeps the old mode
								if (wd[CPC_CFG_FILT_LO +: 2] != CPC_FILT_RESERVED) begin
									s_d.filt = wd[CPC_CFG_FILT_LO +: 2]; // see R15
								end
								s_d.gain = wd[CPC_CFG_GAIN];
								// unsupported rate codes are ignored
								if (wd[CPC_CFG_RATE_LO +: 3] <= CPC_RATE_LAST) begin
									s_d.rate = wd[CPC_CFG_RATE_LO +: 3];
								end
							end
							default: begin
							end
						endcase
					end
				end
			end
			CPC_WR_RESP: begin
				if (S_AXI_BREADY) begin
					s_d.bvalid = 1'b0;
					s_d.awready = 1'b1;
					s_d.wready = 1'b1;
					s_d.wr = CPC_WR_COLLECT;
				end
			end
			default: begin
				s_d.wr = CPC_WR_COLLECT;
				s_d.awready = 1'b1;
				s_d.wready = 1'b1;
				s_d.bvalid = 1'b0;
			end
		endcase

		// read channel: data presented at the edge that takes the address
		unique case (s_q.rd)
			CPC_RD_IDLE: begin
				if (S_AXI_ARVALID) begin
					idx = word_index(S_AXI_ARADDR);
					s_d.arready = 1'b0;
					s_d.rvalid = 1'b1;
					s_d.rd = CPC_RD_DATA;
					s_d.rresp = is_mapped(idx) ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
					s_d.rdata = 32'h0000_0000;
					unique case (idx)
						CPC_IDX_TRACK: s_d.rdata[7:0] = s_q.track;
						CPC_IDX_ADC_ONE: s_d.rdata[7:0] = s_q.adc_one;
						CPC_IDX_ADC_TWO: s_d.rdata[7:0] = s_q.adc_two;
						CPC_IDX_FAST: s_d.rdata[7:0] = s_q.fast;
						CPC_IDX_PATH_CFG: begin
							s_d.rdata[CPC_CFG_FILT_LO +: 2] = s_q.filt;
							s_d.rdata[CPC_CFG_GAIN] = s_q.gain;
							s_d.rdata[CPC_CFG_RATE_LO +: 3] = s_q.rate;
						end
						// live derived state of the paths
						CPC_IDX_STATUS: s_d.rdata = {7'h00, s_q.gate_bits,
							s_q.gain_two, s_q.data_inv, s_q.ref_full,
							s_q.tracking, 2'h0, s_q.offset_pct, 2'h0,
							s_q.lead_samples};
						default: begin
						end
					endcase
				end
			end
			CPC_RD_DATA: begin
				if (S_AXI_RREADY) begin
					s_d.rvalid = 1'b0;
					s_d.arready = 1'b1;
					s_d.rd = CPC_RD_IDLE;
				end
			end
			default: begin
				s_d.rd = CPC_RD_IDLE;
				s_d.arready = 1'b1;
				s_d.rvalid = 1'b0;
			end
		endcase
	end

	// single state register; settings and handshakes reset together
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			s_q <= '0;
			s_q.track <= CPC_RST_TRACK;
			s_q.adc_one <= CPC_RST_ADC_ONE;
			s_q.adc_two <= CPC_RST_ADC_TWO;
			s_q.fast <= CPC_RST_FAST;
			s_q.filt <= CPC_RST_FILT;
			s_q.rate <= CPC_RST_RATE;
			s_q.wr <= CPC_WR_COLLECT;
			s_q.rd <= CPC_RD_IDLE;
			s_q.awready <= 1'b1;
			s_q.wready <= 1'b1;
			s_q.arready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// bus outputs
	assign S_AXI_AWREADY = s_q.awready;
	assign S_AXI_WREADY = s_q.wready;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = s_q.arready;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RRESP = s_q.rresp;
	assign S_AXI_RDATA = s_q.rdata;

	// supply reference path
	assign FIFTH_DAC_TRACKING = s_q.tracking; // see R15
	assign SUPPLY_REF_FULL_SCALE = s_q.ref_full; // see R1
	assign FIFTH_DAC_DATA_INVERT = s_q.data_inv; // see R2
	assign SUPPLY_TRACK_GAIN_TWO = s_q.gain_two; // see R16
	assign SUPPLY_DC_OFFSET_PCT = s_q.offset_pct; // see R3 R4
	// no lead change guard here; software keeps paths quiet first
	assign LEAD_DELAY_SAMPLES = s_q.lead_samples; // see R5 R7

	// adc path controls straight from the register bits
	assign SUPPLY_LEVEL_SEL = s_q.adc_one[CPC_ADC1_LEVEL];
	assign HIGHPASS_EN = s_q.adc_one[CPC_ADC1_HPF]; // see R9
	assign ADC_POLARITY_FLIP = s_q.adc_one[3:0]; // see R10
	assign ADC_SILENCE = s_q.adc_two[CPC_ADC2_SILENCE_LO +: 4]; // see R11
	assign ADC_POWER_OFF = s_q.adc_two[CPC_ADC2_POWER_LO +: 4]; // see R12

	// fast path controls
	assign FAST_PATH_GATE_BITS = s_q.gate_bits; // see R13
	assign FAST_PATH_POLARITY_FLIP = s_q.fast[3:0]; // see R14
endmodule // cpc_path_regs
`default_nettype wire

// ### testbench/cpc_path_regs_properties.sv
// concurrent checks on the codec path control bank ports
`timescale 1ns/1ps
`default_nettype none
module cpc_path_regs_properties (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic FIFTH_DAC_TRACKING,
	input wire logic SUPPLY_REF_FULL_SCALE,
	input wire logic FIFTH_DAC_DATA_INVERT,
	input wire logic SUPPLY_TRACK_GAIN_TWO,
	input wire logic [5:0] SUPPLY_DC_OFFSET_PCT,
	input wire logic [5:0] LEAD_DELAY_SAMPLES,
	input wire logic [4:0] FAST_PATH_GATE_BITS
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RST);

	// fifth dac reference and polarity decode
	a_full_needs_track: assert property (SUPPLY_REF_FULL_SCALE |->
		FIFTH_DAC_TRACKING && !FIFTH_DAC_DATA_INVERT)
		else $error("full scale reference outside tracking mode");
	a_invert_off_track: assert property (FIFTH_DAC_DATA_INVERT |->
		!FIFTH_DAC_TRACKING) else $error("data invert in tracking mode");
	a_gain_needs_flip: assert property (SUPPLY_TRACK_GAIN_TWO |->
		SUPPLY_REF_FULL_SCALE || FIFTH_DAC_DATA_INVERT)
		else $error("gain two without flip bit");
	// offset steps of three, doubled only with gain two
	a_offset_plain: assert property (!SUPPLY_TRACK_GAIN_TWO |->
		SUPPLY_DC_OFFSET_PCT % 3 == 0 && SUPPLY_DC_OFFSET_PCT <= 21)
		else $error("offset not a plain step");
	a_offset_double: assert property (SUPPLY_TRACK_GAIN_TWO |->
		SUPPLY_DC_OFFSET_PCT % 6 == 0 && SUPPLY_DC_OFFSET_PCT <= 42)
		else $error("offset not a doubled step");
	a_lead_bound: assert property (LEAD_DELAY_SAMPLES <= 48)
		else $error("lead delay beyond largest count");
	a_gate_codes: assert property (FAST_PATH_GATE_BITS inside
		{5'h00, [5'h0D:5'h12], 5'h18}) else $error("gate depth not legal");
	// bus answers
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
		S_AXI_RVALID && !S_AXI_ARREADY) else $error("read not answered");
	a_bvalid_clear: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
		!S_AXI_BVALID) else $error("write response not retired");

	c_full_scale: cover property (SUPPLY_REF_FULL_SCALE);
	c_gain_two: cover property (SUPPLY_TRACK_GAIN_TWO);
	c_gate_wide: cover property (FAST_PATH_GATE_BITS == 5'h18);
endmodule // cpc_path_regs_properties

bind cpc_path_regs cpc_path_regs_properties u_props (
	.CLK_SYS(CLK_SYS), .RST(RST), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.FIFTH_DAC_TRACKING(FIFTH_DAC_TRACKING),
	.SUPPLY_REF_FULL_SCALE(SUPPLY_REF_FULL_SCALE),
	.FIFTH_DAC_DATA_INVERT(FIFTH_DAC_DATA_INVERT),
	.SUPPLY_TRACK_GAIN_TWO(SUPPLY_TRACK_GAIN_TWO),
	.SUPPLY_DC_OFFSET_PCT(SUPPLY_DC_OFFSET_PCT),
	.LEAD_DELAY_SAMPLES(LEAD_DELAY_SAMPLES),
	.FAST_PATH_GATE_BITS(FAST_PATH_GATE_BITS));
`default_nettype wire

// ### testbench/cpc_path_regs_tb.sv
// self-checking bench for the codec path control register bank
`timescale 1ns/1ps
`default_nettype none
module cpc_path_regs_tb
	import cpc_pkg::*;
;
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, trk, full, inv, gain2, lvl, hpf;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] pct, lead;
	logic [3:0] apol, asil, aoff, fpol, wstrb;
	logic [4:0] gate;
	int errors, compares;

	cpc_path_regs DUT (
		.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .FIFTH_DAC_TRACKING(trk),
		.SUPPLY_REF_FULL_SCALE(full), .FIFTH_DAC_DATA_INVERT(inv),
		.SUPPLY_TRACK_GAIN_TWO(gain2), .SUPPLY_DC_OFFSET_PCT(pct),
		.LEAD_DELAY_SAMPLES(lead), .SUPPLY_LEVEL_SEL(lvl),
		.HIGHPASS_EN(hpf), .ADC_POLARITY_FLIP(apol), .ADC_SILENCE(asil),
		.ADC_POWER_OFF(aoff), .FAST_PATH_GATE_BITS(gate),
		.FAST_PATH_POLARITY_FLIP(fpol));

	// free running system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string name, input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
		// idle edge: the next call never reassigns bready in this step
		@(posedge clk);
	endtask

	task automatic rdreg(input logic [5:0] idx);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask

	// reset contents of the four coined registers and the config word
	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			rdreg(CPC_IDX_TRACK + 6'(i));
			chk("reset value", rd, 32'h0);
		end
		rdreg(CPC_IDX_PATH_CFG);
		chk("config reset", rd, 32'h00000020);
		rdreg(CPC_IDX_STATUS);
		chk("status reset", rd, 32'h00D00000);
	endtask

	// flip bit meaning depends on the filter select
	task automatic t_flip;
		wr(CPC_IDX_PATH_CFG, 8'h22);
		wr(CPC_IDX_TRACK, 8'h80);
		chk("tracking", trk, 1'b1);
		chk("full scale", full, 1'b1);
		chk("data invert", inv, 1'b0);
		wr(CPC_IDX_PATH_CFG, 8'h23);
		chk("reserved filter", trk, 1'b1);
		wr(CPC_IDX_PATH_CFG, 8'h20);
		chk("full off track", full, 1'b0);
		chk("invert off track", inv, 1'b1);
		wr(CPC_IDX_TRACK, 8'h00);
		chk("invert cleared", inv, 1'b0);
	endtask

	// every offset code, plain and doubled
	task automatic t_offset;
		for (int g = 0; g < 2; g++) begin
			wr(CPC_IDX_PATH_CFG, g ? 8'h24 : 8'h20);
			for (int c = 0; c < 8; c++) begin
				wr(CPC_IDX_TRACK, {g[0], c[2:0], 4'h0});
				chk("offset pct", pct, 32'(c * 3 * (g + 1)));
				chk("gain two", gain2, g[0]);
			end
		end
	endtask

	// lead codes against sample counts at a few rates
	task automatic t_lead;
		logic [2:0] rt [5] = '{3'h2, 3'h2, 3'h2, 3'h5, 3'h0};
		logic [3:0] cd [5] = '{4'h5, 4'hF, 4'h0, 4'hF, 4'h1};
		logic [5:0] ns [5] = '{6'h0C, 6'h18, 6'h00, 6'h30, 6'h03};
		// adc paths silenced and powered off before the lead code moves
		wr(CPC_IDX_ADC_TWO, 8'hFF);
		chk("paths down", {asil, aoff}, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			wr(CPC_IDX_PATH_CFG, {1'b0, rt[i], 4'h0});
			wr(CPC_IDX_TRACK, {4'h0, cd[i]});
			chk("lead samples", lead, ns[i]);
		end
	endtask

	// adc controls, reserved bits read as zero
	task automatic t_adc;
		wr(CPC_IDX_ADC_ONE, 8'hFF);
		rdreg(CPC_IDX_ADC_ONE);
		chk("adc one read", rd, 32'h3F);
		chk("adc one out", {lvl, hpf, apol}, 6'h3F);
		wr(CPC_IDX_ADC_ONE, 8'h05);
		chk("adc one low", {lvl, hpf, apol}, 6'h05);
		wr(CPC_IDX_ADC_TWO, 8'hA5);
		chk("mapped write", resp, CPC_RESP_OKAY);
		chk("adc silence", asil, 4'hA);
		chk("adc power off", aoff, 4'h5);
		rdreg(CPC_IDX_ADC_TWO);
		chk("mapped read", resp, CPC_RESP_OKAY);
		chk("adc two read", rd, 32'hA5);
		// lane 0 strobe low: word accepted, register untouched
		wstrb <= 4'hE;
		wr(CPC_IDX_ADC_TWO, 8'h00);
		chk("masked resp", resp, CPC_RESP_OKAY);
		chk("masked silence", asil, 4'hA);
		chk("masked power", aoff, 4'h5);
		wstrb <= 4'hF;
	endtask

	// every gate code, with a changing invert pattern and the reserved bit set
	task automatic t_fast;
		for (int c = 0; c < 8; c++) begin
			wr(CPC_IDX_FAST, {c[2:0], 1'b1, c[3:0] ^ 4'h5});
			chk("gate bits", gate, c < 6 ? 13 + c : (c == 6 ? 24 : 0));
			chk("fast invert", fpol, c[3:0] ^ 4'h5);
			rdreg(CPC_IDX_FAST);
			chk("fast read", rd, {c[2:0], 1'b0, c[3:0] ^ 4'h5});
		end
	endtask

	// unmapped word refused both ways
	task automatic t_unmapped;
		wr(6'h20, 8'hFF);
		chk("unmapped write", resp, CPC_RESP_SLVERR);
		rdreg(6'h20);
		chk("unmapped read", resp, CPC_RESP_SLVERR);
		chk("unmapped data", rd, 32'h0);
	endtask

	task automatic finish_test;
		if (errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// a hung handshake ends the run through the same verdict
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		finish_test;
	end

	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_flip;
		t_offset;
		t_lead;
		t_adc;
		t_fast;
		t_unmapped;
		finish_test;
	end
endmodule // cpc_path_regs_tb
`default_nettype wire
